/* ubsd_top.sv */
// Serial unit with break send and break detect, APB registers and interrupt.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
//
// Overview of operation
// - Break is start, twelve zeros, stop.
// - Break starts on enable, request, data write.
// - Break data byte is discarded, zeros sent.
// - Hardware clears break request after stop.
// - Next byte buffered, sent after break.
// - Shift empty shows busy during break.
// - Buffer empty flag gates next write.
// - Break received: avail, framing error, 00h.
// - Wake watches two edges, then receives.
module ubsd_top #(
    parameter logic [15:0] DIV_RESET = ubsd_pkg::DIVISOR_RESET
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin,
    output logic             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                     tx_enable_ctl;
        logic                     break_send_request;
        logic [7:0]               txbuf;
        logic                     txbuf_v;
        ubsd_pkg::ubsd_tx_state_t tx_st;
        logic [7:0]               tx_sh;
        logic [3:0]               tx_cnt;
        logic                     tx_brk;
        logic                     tx_pin;
        logic                     rx_en;
        logic                     wake_en;
        ubsd_pkg::ubsd_rx_state_t rx_st;
        logic [7:0]               rx_sh;
        logic [3:0]               rx_cnt;
        logic [7:0]               rx_data;
        logic                     rx_avail;
        logic                     framing_error_flag;
        logic                     rx_prev;
        logic [15:0]              divisor;
        logic                     autobaud_arm;
        logic [3:0]               irq_st;
        logic [3:0]               irq_mask;
        logic                     irq;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
    } ubsd_state_t;

    ubsd_state_t s_q;
    ubsd_state_t s_d;

    logic tx_bit_tick;
    logic rx_mid_tick;

    function automatic logic ubsd_hit(input logic [7:0] a, input logic [7:0] off);
        ubsd_hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------------
    // one bit time
    ubsd_baud_gen #(
        .CW       (16)
    ) u_tx_baud (
        .clk      (clk),
        .rst      (rst),
        .restart  (s_q.tx_st == ubsd_pkg::TX_IDLE),
        .divisor  (s_q.divisor),
        .bit_tick (tx_bit_tick),
        .mid_tick ()
    );

    ubsd_baud_gen #(
        .CW       (16)
    ) u_rx_baud (
        .clk      (clk),
        .rst      (rst),
        .restart  (s_q.rx_st == ubsd_pkg::RX_IDLE || s_q.rx_st == ubsd_pkg::RX_WAITH
                   || s_q.rx_st == ubsd_pkg::RX_WAKE),
        .divisor  (s_q.divisor),
        .bit_tick (),
        .mid_tick (rx_mid_tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd_rx;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic       mapped;
    logic [31:0] rdata;

    always_comb
    begin
        s_d     = s_q;
        irq_set = '0;
        irq_clr = '0;
        rdata   = '0;
        // Access phase completes at the edge where our registered pready is high.
        acc     = psel && penable && s_q.pready;
        wr      = acc && pwrite;
        rd_rx   = acc && !pwrite && ubsd_hit(paddr, ubsd_pkg::RX_DATA_REG);
        mapped  = ubsd_hit(paddr, ubsd_pkg::TX_STATUS_CONTROL_REG)
               || ubsd_hit(paddr, ubsd_pkg::TX_DATA_REG)
               || ubsd_hit(paddr, ubsd_pkg::RX_STATUS_CONTROL_REG)
               || ubsd_hit(paddr, ubsd_pkg::RX_DATA_REG)
               || ubsd_hit(paddr, ubsd_pkg::BAUD_CONTROL_REG)
               || ubsd_hit(paddr, ubsd_pkg::IRQ_STATUS_REG)
               || ubsd_hit(paddr, ubsd_pkg::IRQ_MASK_REG);

        // Register writes.
        if (wr && ubsd_hit(paddr, ubsd_pkg::TX_STATUS_CONTROL_REG))
        begin
            s_d.tx_enable_ctl      = pwdata[ubsd_pkg::TX_ENABLE_CTL_BIT];
            s_d.break_send_request = pwdata[ubsd_pkg::BREAK_SEND_REQUEST_BIT];
        end
        if (wr && ubsd_hit(paddr, ubsd_pkg::TX_DATA_REG) && !s_q.txbuf_v)
        begin
            s_d.txbuf   = pwdata[7:0];
            s_d.txbuf_v = 1'b1;
        end
        if (wr && ubsd_hit(paddr, ubsd_pkg::RX_STATUS_CONTROL_REG))
        begin
            s_d.rx_en   = pwdata[ubsd_pkg::RX_ENABLE_BIT];
            s_d.wake_en = pwdata[ubsd_pkg::WAKE_ENABLE_BIT];
        end
        if (wr && ubsd_hit(paddr, ubsd_pkg::BAUD_CONTROL_REG))
        begin
            s_d.divisor      = pwdata[15:0];
            s_d.autobaud_arm = pwdata[ubsd_pkg::AUTOBAUD_ARM_BIT];
        end
        if (wr && ubsd_hit(paddr, ubsd_pkg::IRQ_STATUS_REG))
        begin
            irq_clr = pwdata[3:0];
        end
        if (wr && ubsd_hit(paddr, ubsd_pkg::IRQ_MASK_REG))
        begin
            s_d.irq_mask = pwdata[3:0];
        end
        // Reading the data register consumes the character and its error.
        if (rd_rx)
        begin
            s_d.rx_avail = 1'b0;
            s_d.framing_error_flag     = 1'b0;
        end

        // Transmitter.
        unique case (s_q.tx_st)
            ubsd_pkg::TX_IDLE:
            begin
                if (s_q.txbuf_v && s_q.tx_enable_ctl)
                begin
                    s_d.tx_st   = ubsd_pkg::TX_START;
                    s_d.tx_pin  = 1'b0;
                    s_d.tx_sh   = s_q.txbuf;
                    s_d.tx_brk  = s_q.break_send_request;
                    s_d.txbuf_v = 1'b0;
                    irq_set[ubsd_pkg::IRQ_TX_EMPTY_BIT] = 1'b1;
                end
            end
            ubsd_pkg::TX_START:
            begin
                if (tx_bit_tick)
                begin
                    s_d.tx_st  = ubsd_pkg::TX_DATA;
                    s_d.tx_cnt = '0;
                    s_d.tx_pin = s_q.tx_brk ? 1'b0 : s_q.tx_sh[0];
                    s_d.tx_sh  = {1'b0, s_q.tx_sh[7:1]};
                end
            end
            ubsd_pkg::TX_DATA:
            begin
                if (tx_bit_tick)
                begin
                    if (s_q.tx_cnt == (s_q.tx_brk ? ubsd_pkg::BREAK_LAST_BIT
                                                  : ubsd_pkg::DATA_LAST_BIT))
                    begin
                        s_d.tx_st  = ubsd_pkg::TX_STOP;
                        s_d.tx_pin = 1'b1;
                    end
                    else
                    begin
                        s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                        s_d.tx_pin = s_q.tx_brk ? 1'b0 : s_q.tx_sh[0];
                        s_d.tx_sh  = {1'b0, s_q.tx_sh[7:1]};
                    end
                end
            end
            ubsd_pkg::TX_STOP:
            begin
                if (tx_bit_tick)
                begin
                    s_d.tx_st = ubsd_pkg::TX_IDLE;
                    if (s_q.tx_brk)
                    begin
                        s_d.break_send_request = 1'b0;
                    end
                    s_d.tx_brk = 1'b0;
                end
            end
        endcase

        // Receiver.
        s_d.rx_prev = serial_rx_pin;
        unique case (s_q.rx_st)
            ubsd_pkg::RX_IDLE:
            begin
                if (s_q.rx_prev && !serial_rx_pin)
                begin
                    if (s_q.wake_en)
                    begin
                        s_d.rx_st = ubsd_pkg::RX_WAKE;
                    end
                    else if (s_q.rx_en)
                    begin
                        s_d.rx_st = ubsd_pkg::RX_START;
                    end
                end
            end
            ubsd_pkg::RX_WAKE:
            begin
                if (!s_q.rx_prev && serial_rx_pin)
                begin
                    s_d.rx_st   = ubsd_pkg::RX_IDLE;
                    s_d.wake_en = 1'b0;
                    irq_set[ubsd_pkg::IRQ_WAKE_BIT]    = 1'b1;
                    irq_set[ubsd_pkg::IRQ_RX_DATA_BIT] = 1'b1;
                end
            end
            ubsd_pkg::RX_START:
            begin
                if (rx_mid_tick)
                begin
                    s_d.rx_st  = serial_rx_pin ? ubsd_pkg::RX_IDLE : ubsd_pkg::RX_DATA;
                    s_d.rx_cnt = '0;
                end
            end
            ubsd_pkg::RX_DATA:
            begin
                if (rx_mid_tick)
                begin
                    s_d.rx_sh = {serial_rx_pin, s_q.rx_sh[7:1]};
                    if (s_q.rx_cnt == ubsd_pkg::DATA_LAST_BIT)
                    begin
                        s_d.rx_st = ubsd_pkg::RX_STOP;
                    end
                    else
                    begin
                        s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    end
                end
            end
            ubsd_pkg::RX_STOP:
            begin
                if (rx_mid_tick)
                begin
                    // break shows as error with 00h
                    s_d.rx_data  = s_q.rx_sh;
                    s_d.rx_avail = 1'b1;
                    s_d.framing_error_flag     = !serial_rx_pin;
                    irq_set[ubsd_pkg::IRQ_RX_DATA_BIT] = 1'b1;
                    if (!serial_rx_pin && s_q.rx_sh == ubsd_pkg::BREAK_RX_DATA)
                    begin
                        irq_set[ubsd_pkg::IRQ_BREAK_BIT] = 1'b1;
                    end
                    // A low stop bit means the line is held; wait for idle first.
                    s_d.rx_st = serial_rx_pin ? ubsd_pkg::RX_IDLE : ubsd_pkg::RX_WAITH;
                end
            end
            ubsd_pkg::RX_WAITH:
            begin
                if (serial_rx_pin)
                begin
                    s_d.rx_st = ubsd_pkg::RX_IDLE;
                end
            end
            default:
            begin
                s_d.rx_st = ubsd_pkg::RX_IDLE;
            end
        endcase

        // Sticky status: a new event in the clearing cycle survives.
        s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_set;
        s_d.irq    = |(s_d.irq_st & s_d.irq_mask);

        // Read mux and APB answer, one wait state.
        if (ubsd_hit(paddr, ubsd_pkg::TX_STATUS_CONTROL_REG))
        begin
            rdata[ubsd_pkg::TX_ENABLE_CTL_BIT]        = s_q.tx_enable_ctl;
            rdata[ubsd_pkg::BREAK_SEND_REQUEST_BIT]   = s_q.break_send_request;
            rdata[ubsd_pkg::TX_SHIFT_EMPTY_BIT]       = (s_q.tx_st == ubsd_pkg::TX_IDLE);
            rdata[ubsd_pkg::TX_BUFFER_EMPTY_FLAG_BIT] = !s_q.txbuf_v;
        end
        else if (ubsd_hit(paddr, ubsd_pkg::RX_STATUS_CONTROL_REG))
        begin
            rdata[ubsd_pkg::RX_ENABLE_BIT]          = s_q.rx_en;
            rdata[ubsd_pkg::FRAMING_ERROR_FLAG_BIT] = s_q.framing_error_flag;
            rdata[ubsd_pkg::RX_DATA_AVAIL_FLAG_BIT] = s_q.rx_avail;
            rdata[ubsd_pkg::WAKE_ENABLE_BIT]        = s_q.wake_en;
        end
        else if (ubsd_hit(paddr, ubsd_pkg::RX_DATA_REG))
        begin
            rdata[7:0] = s_q.rx_data;
        end
        else if (ubsd_hit(paddr, ubsd_pkg::BAUD_CONTROL_REG))
        begin
            rdata[15:0]                       = s_q.divisor;
            rdata[ubsd_pkg::AUTOBAUD_ARM_BIT] = s_q.autobaud_arm;
        end
        else if (ubsd_hit(paddr, ubsd_pkg::IRQ_STATUS_REG))
        begin
            rdata[3:0] = s_q.irq_st;
        end
        else if (ubsd_hit(paddr, ubsd_pkg::IRQ_MASK_REG))
        begin
            rdata[3:0] = s_q.irq_mask;
        end

        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = psel && penable && !s_q.pready && !mapped;
        s_d.prdata  = (psel && penable && !s_q.pready && !pwrite) ? rdata : '0;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q          <= '0;
            s_q.tx_st    <= ubsd_pkg::TX_IDLE;
            s_q.rx_st    <= ubsd_pkg::RX_IDLE;
            s_q.tx_pin   <= 1'b1;
            s_q.rx_prev  <= 1'b1;
            s_q.divisor  <= DIV_RESET;
            s_q.irq_mask <= ubsd_pkg::IRQ_MASK_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata        = s_q.prdata;
    assign pready        = s_q.pready;
    assign pslverr       = s_q.pslverr;
    assign serial_tx_pin = s_q.tx_pin;
    assign irq           = s_q.irq;

endmodule

/* ubsd_pkg.sv */
// Package with register map, field positions, reset values and state codes.
package ubsd_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TX_STATUS_CONTROL_REG = 8'h00;
    localparam logic [7:0] TX_DATA_REG           = 8'h04;
    localparam logic [7:0] RX_STATUS_CONTROL_REG = 8'h08;
    localparam logic [7:0] RX_DATA_REG           = 8'h0C;
    localparam logic [7:0] BAUD_CONTROL_REG      = 8'h10;
    localparam logic [7:0] IRQ_STATUS_REG        = 8'h14;
    localparam logic [7:0] IRQ_MASK_REG          = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TX_ENABLE_CTL_BIT        = 0;
    localparam int BREAK_SEND_REQUEST_BIT   = 1;
    localparam int TX_SHIFT_EMPTY_BIT       = 2;
    localparam int TX_BUFFER_EMPTY_FLAG_BIT = 3;

    localparam int RX_ENABLE_BIT            = 0;
    localparam int FRAMING_ERROR_FLAG_BIT   = 1;
    localparam int RX_DATA_AVAIL_FLAG_BIT   = 2;
    localparam int WAKE_ENABLE_BIT          = 3;

    localparam int AUTOBAUD_ARM_BIT         = 16;

    localparam int IRQ_TX_EMPTY_BIT         = 0;
    localparam int IRQ_RX_DATA_BIT          = 1;
    localparam int IRQ_BREAK_BIT            = 2;
    localparam int IRQ_WAKE_BIT             = 3;
    localparam int IRQ_WIDTH                = 4;

    // ------------------------------------------------------------------
    // Reset values and character shape
    // ------------------------------------------------------------------
    localparam logic [15:0] DIVISOR_RESET   = 16'h0010;
    localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
    localparam logic [3:0]  DATA_LAST_BIT   = 4'h7;
    localparam logic [3:0]  BREAK_LAST_BIT  = 4'hB;
    localparam logic [7:0]  BREAK_RX_DATA   = 8'h00;

    // ------------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE  = 2'h0,
        TX_START = 2'h1,
        TX_DATA  = 2'h3,
        TX_STOP  = 2'h2
    } ubsd_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h3,
        RX_STOP  = 3'h2,
        RX_WAITH = 3'h6,
        RX_WAKE  = 3'h4
    } ubsd_rx_state_t;

endpackage

/* ubsd_baud_gen.sv */
// Bit-time generator giving an end-of-bit tick and a mid-bit tick.
`timescale 1ns/10ps
module ubsd_baud_gen #(
    parameter int CW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          restart,
    input  wire logic [CW-1:0] divisor,
    output logic               bit_tick,
    output logic               mid_tick
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // A divisor below two is treated as two; at two both ticks still fall on the same count.
    logic [CW-1:0] div_eff;

    always_comb
    begin
        div_eff  = (divisor < CW'(2)) ? CW'(2) : divisor;
        bit_tick = (cnt_q == div_eff - CW'(1));
        mid_tick = (cnt_q == (div_eff >> 1));
        if (restart || bit_tick)
        begin
            cnt_d = '0;
        end
        else
        begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule

/* ubsd_monitor.sv */
// Checker of bus handshake and transmit line timing for the serial unit.
`timescale 1ns/10ps
module ubsd_monitor #(
    parameter logic [15:0] DIV_RESET = ubsd_pkg::DIVISOR_RESET
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_rx_pin,
    input wire logic        serial_tx_pin,
    input wire logic        irq
);
    // --------------------
    // Line run lengths
    // --------------------
    logic [31:0] div_q;
    logic [31:0] low_q;
    logic [31:0] high_q;
    logic        rd_st;
    assign rd_st = psel && penable && pready && !pwrite && paddr == ubsd_pkg::TX_STATUS_CONTROL_REG;
    // High time starts large so that a prompt first character is not taken for a short stop.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q  <= {16'h0, DIV_RESET};
            low_q  <= 32'h0;
            high_q <= 32'h10000;
        end
        else
        begin
            if (psel && penable && pready && pwrite && paddr == ubsd_pkg::BAUD_CONTROL_REG)
                div_q <= {16'h0, pwdata[15:0]};
            low_q  <= serial_tx_pin ? 32'h0 : low_q + 32'h1;
            high_q <= serial_tx_pin ? high_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_ready_wait; psel && penable && !pready |=> pready; endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("pready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_rdata_quiet; !(pready && !pwrite) |-> prdata == 32'h0; endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("prdata not zero outside read");
    property p_whole_bits; $rose(serial_tx_pin) && div_q != 32'h0 |-> low_q % div_q == 32'h0;
    endproperty
    a_whole_bits: assert property (p_whole_bits)
        else $error("low run not whole bits");
    property p_run_len; $rose(serial_tx_pin) |-> low_q <= 9 * div_q || low_q == 13 * div_q;
    endproperty
    a_run_len: assert property (p_run_len)
        else $error("bad low run length");
    property p_stop_first; $fell(serial_tx_pin) |-> high_q >= div_q; endproperty
    a_stop_first: assert property (p_stop_first)
        else $error("stop bit too short");
    property p_busy_low;
        rd_st && !serial_tx_pin && !$past(serial_tx_pin) |-> !prdata[ubsd_pkg::TX_SHIFT_EMPTY_BIT];
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("shift empty while sending");
    property p_req_held;
        rd_st && low_q > 9 * div_q + 2 |-> prdata[ubsd_pkg::BREAK_SEND_REQUEST_BIT];
    endproperty
    a_req_held: assert property (p_req_held)
        else $error("break request dropped early");
endmodule
bind ubsd_top ubsd_monitor #(.DIV_RESET(DIV_RESET)) ubsd_monitor_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .irq(irq)
);

/* ubsd_node_model.sv */
// Far serial node: decodes the transmit line and drives the receive line.
`timescale 1ns/10ps
module ubsd_node_model #(
    parameter int DIV = 8
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    // --------------------
    // Driver and decoder
    // --------------------
    logic [7:0] got_q[$];
    logic       stop_q[$];
    int         low_cnt;
    int         low_max;
    initial
        line_out = 1'b1;
    task automatic drive(input logic lvl, input int n);
        line_out <= lvl;
        repeat (n) @(posedge clk);
    endtask
    task automatic send_char(input logic [7:0] d, input logic stop);
        drive(1'b0, DIV);
        for (int i = 0; i < 8; i++)
            drive(d[i], DIV);
        drive(stop, DIV);
        drive(1'b1, DIV);
    endtask
    always @(posedge clk)
    begin
        low_cnt <= line_in ? 0 : low_cnt + 1;
        if (line_in && low_cnt > low_max)
            low_max <= low_cnt;
    end
    // A low stop bit means the next start can only follow once the line is high again.
    initial
    begin
        logic [7:0] d;
        forever
        begin
            @(negedge line_in);
            repeat (DIV / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(posedge clk);
                d[i] = line_in;
            end
            repeat (DIV) @(posedge clk);
            got_q.push_back(d);
            stop_q.push_back(line_in);
            wait (line_in === 1'b1);
        end
    end
endmodule

/* uart_break_send_detect_tb_top.sv */
// Self-checking bench for break send, break receive, wake and interrupts.
`timescale 1ns/10ps
module uart_break_send_detect_tb_top;
    localparam int         DIV  = 8;
    localparam logic [7:0] TXS  = ubsd_pkg::TX_STATUS_CONTROL_REG;
    localparam logic [7:0] TXD  = ubsd_pkg::TX_DATA_REG;
    localparam logic [7:0] RXS  = ubsd_pkg::RX_STATUS_CONTROL_REG;
    localparam logic [7:0] RXD  = ubsd_pkg::RX_DATA_REG;
    localparam logic [7:0] BAUD = ubsd_pkg::BAUD_CONTROL_REG;
    localparam logic [7:0] IST  = ubsd_pkg::IRQ_STATUS_REG;
    localparam logic [7:0] IMSK = ubsd_pkg::IRQ_MASK_REG;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_line;
    logic        tx_line;
    logic        irq;
    logic [31:0] rd;
    logic        err_seen;
    int          error_cnt;
    int          num_checks;
    ubsd_top ubsd_top_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_rx_pin(rx_line), .serial_tx_pin(tx_line), .irq(irq)
    );
    ubsd_node_model #(.DIV(DIV)) ubsd_node_model_inst (
        .clk(clk), .line_in(tx_line), .line_out(rx_line)
    );
    // --------------------
    // Tasks
    // --------------------
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The request stays up until pready is seen; the answer is taken at that same edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask
    initial
        forever #2 clk = ~clk;
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    // --------------------
    // Scenarios
    // --------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk("tx status reset", TXS, 32'hC);
        rd_chk("baud reset", BAUD, 32'h10);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped error", {31'h0, err_seen}, 32'h1);
        apb(1'b1, BAUD, 32'h10008);
        rd_chk("baud arm", BAUD, 32'h10008);
        apb(1'b1, IMSK, 32'h1);
        apb(1'b1, TXS, 32'h2);
        apb(1'b1, TXD, 32'hA5);
        repeat (2 * DIV) @(posedge clk);
        check("tx held off", {31'h0, tx_line}, 32'h1);
        apb(1'b1, TXS, 32'h3);
        rd_chk("tx in break", TXS, 32'hB);
        check("tx empty irq", {31'h0, irq}, 32'h1);
        apb(1'b1, TXD, 32'h55);
        rd_chk("tx buffer full", TXS, 32'h3);
        // A read late in the long low run shows the request still armed there.
        repeat (9 * DIV) @(posedge clk);
        rd_chk("break request late", TXS, 32'h3);
        for (int i = 0; i < 4000 && ubsd_node_model_inst.got_q.size() < 2; i++)
            @(posedge clk);
        repeat (DIV) @(posedge clk);
        rd_chk("tx done", TXS, 32'hD);
        check("break data", {24'h0, ubsd_node_model_inst.got_q[0]}, 32'h0);
        check("sync data", {24'h0, ubsd_node_model_inst.got_q[1]}, 32'h55);
        check("break low run", ubsd_node_model_inst.low_max, 13 * DIV);
        rd_chk("tx events", IST, 32'h1);
        apb(1'b1, IMSK, 32'h0);
        @(posedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, IMSK, 32'hF);
        apb(1'b1, IST, 32'h1);
        @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, RXS, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            ubsd_node_model_inst.send_char(k ? 8'h3C : 8'h00, k[0]);
            check("rx irq", {31'h0, irq}, 32'h1);
            rd_chk("rx status", RXS, k ? 32'h5 : 32'h7);
            rd_chk("rx events", IST, k ? 32'h2 : 32'h6);
            rd_chk("rx data", RXD, k ? 32'h3C : 32'h0);
            rd_chk("rx status read", RXS, 32'h1);
            apb(1'b1, IST, 32'hF);
        end
        apb(1'b1, RXS, 32'h9);
        ubsd_node_model_inst.drive(1'b0, DIV);
        ubsd_node_model_inst.drive(1'b1, DIV);
        rd_chk("wake events", IST, 32'hA);
        rd_chk("wake cleared", RXS, 32'h1);
        apb(1'b1, IST, 32'hF);
        ubsd_node_model_inst.send_char(8'h47, 1'b1);
        rd_chk("wake data", RXD, 32'h47);
        rd_chk("wake next events", IST, 32'h2);
        wrap_up();
    end
endmodule
